// ---- common/cot_pkg.sv ----
package cot_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [3:0] ADDR_CONTROL_A   = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B   = 4'h1;
  localparam logic [3:0] ADDR_EVENT_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_INT_CTRL    = 4'h5;
  localparam logic [3:0] ADDR_INT_FLAGS   = 4'h6;
  localparam logic [3:0] ADDR_STATUS      = 4'h7;
  localparam logic [3:0] ADDR_TEMP        = 4'h9;
  localparam logic [3:0] ADDR_COUNT_LO    = 4'hA;
  localparam logic [3:0] ADDR_COUNT_HI    = 4'hB;
  localparam logic [3:0] ADDR_CAPCMP_LO   = 4'hC;
  localparam logic [3:0] ADDR_CAPCMP_HI   = 4'hD;

  // Writable bits of each register; all other bits read as zero
  localparam logic [7:0] MASK_CONTROL_A   = 8'h57;
  localparam logic [7:0] MASK_CONTROL_B   = 8'h77;
  localparam logic [7:0] MASK_EVENT_CTRL  = 8'h51;
  localparam logic [7:0] MASK_ONE_BIT     = 8'h01;
  localparam logic [7:0] RESET_BYTE       = 8'h00;

  // Counter mode codes
  localparam logic [2:0] MODE_FREQ        = 3'h3;
  localparam logic [2:0] MODE_PULSE       = 3'h4;
  localparam logic [2:0] MODE_FREQ_PULSE  = 3'h5;
  localparam logic [2:0] MODE_SINGLE      = 3'h6;
  localparam logic [2:0] MODE_PWM         = 3'h7;

  // Count clock sources
  localparam logic [1:0] CLKSRC_PERIPH    = 2'h0;
  localparam logic [1:0] CLKSRC_HALF      = 2'h1;
  localparam logic [1:0] CLKSRC_PARTNER   = 2'h2;

  localparam int         CLK_PERIOD_NS    = 25;
  localparam int         COUNT_W_DOC      = 16;
  localparam logic [7:0] PWM_ZERO         = 8'h00;

  typedef struct packed {
    logic       rsv7;
    logic       run_in_standby;
    logic       rsv5;
    logic       follow_partner_restart;
    logic       rsv3;
    logic [1:0] clock_source_select;
    logic       enable;
  } cot_ctrl_a_t;

  typedef struct packed {
    logic       rsv7;
    logic       output_select_a;
    logic       output_initial_level;
    logic       output_drive_enable;
    logic       rsv3;
    logic [2:0] counter_mode_select;
  } cot_ctrl_b_t;

  typedef struct packed {
    logic       rsv7;
    logic       filter_enable;
    logic       rsv5;
    logic       edge_select;
    logic [2:0] rsv3_1;
    logic       event_input_enable;
  } cot_ev_ctrl_t;

  // Signals from the companion timer, all on CLK
  typedef struct packed {
    logic clk_tick;
    logic event_tick;
    logic count_on_event;
    logic restart;
  } cot_partner_t;

  typedef enum logic [1:0] {
    CM_IDLE,
    CM_COUNT,
    CM_MEASURED,
    CM_DONE
  } cot_combo_state_t;

endpackage

// ---- verilog/cot_timer.sv ----
`timescale 1ns/1ps
module cot_timer
  import cot_pkg::*;
#(
  parameter int CNT_W = COUNT_W_DOC
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST,
  // Register port
  input  wire logic [3:0]   ADDR,
  input  wire logic [7:0]   WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic      [7:0]   RDATA,
  // Event input, companion timer and sleep
  input  wire logic         EVENT_IN,
  input  wire cot_partner_t PARTNER,
  input  wire logic         SLEEP_STANDBY,
  input  wire logic         SLEEP_POWERDOWN,
  // Outputs
  output logic              WAVE_OUT,
  output logic              EVENT_OUT,
  output logic              CAPTURE_IRQ
);

  if (CNT_W != COUNT_W_DOC) begin : g_width_check
    $error("cot_timer: CNT_W must equal 16, the byte-paired register width");
  end

  cot_ctrl_a_t      ctrl_a_reg;
  cot_ctrl_b_t      ctrl_b_reg;
  cot_ev_ctrl_t     ev_ctrl_reg;
  logic             int_en_reg;
  logic             flag_reg;
  logic [7:0]       temp_reg;
  logic [7:0]       rdata_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] cap_reg;
  logic             sync1_reg;
  logic             sync2_reg;
  logic             sync3_reg;
  logic             level_reg;
  logic [3:0]       hist_reg;
  logic             filt_reg;
  logic             prev_reg;
  logic             half_reg;
  logic             enable_d_reg;
  logic             run_reg;
  logic             hold_reg;
  logic             wave_reg;
  logic             evout_reg;
  cot_combo_state_t cm_state_reg;

  logic [2:0]       mode;
  logic             halt;
  logic             active;
  logic             tick;
  logic             ev_en;
  logic             sel_level;
  logic             rise;
  logic             fall;
  logic             lead_edge;
  logic             trail_edge;
  logic             output_select_a_edge;
  logic             ss_trig;
  logic             ss_start;
  logic             ss_stop;
  logic             do_capture;
  logic             do_restart;
  logic             count_run;
  logic             set_flag;
  logic             flag_clr;
  logic             cap_hi_rd;
  logic             pwm_level;
  logic             wave_next;
  logic [7:0]       rd_mux;

  assign mode = ctrl_b_reg.counter_mode_select;

  // Sleep gating and count clock selection
  assign halt   = SLEEP_POWERDOWN | (SLEEP_STANDBY & ~ctrl_a_reg.run_in_standby);
  assign active = ctrl_a_reg.enable & ~halt;

  always_ff @(posedge CLK) begin
    if (RST) begin
      half_reg <= 1'b0;
    end else if (active) begin
      half_reg <= ~half_reg;
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (ctrl_a_reg.clock_source_select)
      CLKSRC_PERIPH: tick = active;
      CLKSRC_HALF:   tick = active & half_reg;
      CLKSRC_PARTNER: begin
        tick = active & (PARTNER.count_on_event ? PARTNER.event_tick
                                                : PARTNER.clk_tick);
      end
      default:       tick = 1'b0;
    endcase
  end

  // Event input: three-stage synchroniser, agreement stage, noise filter
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      sync1_reg <= EVENT_IN;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        level_reg <= sync3_reg;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hist_reg <= 4'h0;
      filt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[2:0], level_reg};
      if (&hist_reg) begin
        filt_reg <= 1'b1;
      end else if (~|hist_reg) begin
        filt_reg <= 1'b0;
      end
    end
  end

  assign sel_level = ev_ctrl_reg.filter_enable ? filt_reg : level_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sel_level;
    end
  end

  // Edge detection; edge select swaps the roles of the two edges in capture modes
  assign ev_en      = ev_ctrl_reg.event_input_enable & active;
  assign rise       = ev_en & sel_level & ~prev_reg;
  assign fall       = ev_en & ~sel_level & prev_reg;
  assign lead_edge  = ev_ctrl_reg.edge_select ? fall : rise;
  assign trail_edge = ev_ctrl_reg.edge_select ? rise : fall;
  assign output_select_a_edge = ev_en & (sync2_reg != sync3_reg)
                      & (ev_ctrl_reg.edge_select | sync2_reg);

  // Single shot start and stop
  assign ss_trig  = ctrl_b_reg.output_select_a ? output_select_a_edge
                  : (ev_ctrl_reg.edge_select ? (rise | fall) : rise);
  assign ss_start = (mode == MODE_SINGLE) & ~run_reg & ~hold_reg
                    & (ss_trig | (active & ~enable_d_reg
                                  & (count_reg != cap_reg)));
  assign ss_stop  = (mode == MODE_SINGLE) & run_reg & tick
                    & (count_reg == cap_reg);

  // Per-mode capture, restart and flag events
  always_comb begin
    do_capture = 1'b0;
    do_restart = 1'b0;
    set_flag   = 1'b0;
    count_run  = tick;
    unique case (mode)
      MODE_FREQ: begin
        do_capture = lead_edge;
        do_restart = lead_edge;
        set_flag   = lead_edge;
      end
      MODE_PULSE: begin
        do_restart = lead_edge;
        do_capture = trail_edge;
        set_flag   = trail_edge;
      end
      MODE_FREQ_PULSE: begin
        count_run  = tick & ((cm_state_reg == CM_COUNT) | (cm_state_reg == CM_MEASURED));
        do_restart = (cm_state_reg == CM_IDLE) & lead_edge;
        do_capture = (cm_state_reg == CM_COUNT) & trail_edge;
        set_flag   = (cm_state_reg == CM_MEASURED) & lead_edge;
      end
      MODE_SINGLE: begin
        count_run  = tick & run_reg & ~ss_stop;
        do_restart = ss_start;
      end
      default: begin
        count_run  = tick;
      end
    endcase
  end

  // Register access
  assign cap_hi_rd = RD & (ADDR == ADDR_CAPCMP_HI);
  assign flag_clr  = cap_hi_rd
                   | (WR & (ADDR == ADDR_INT_FLAGS) & WDATA[0]);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_a_reg  <= cot_ctrl_a_t'(RESET_BYTE);
      ctrl_b_reg  <= cot_ctrl_b_t'(RESET_BYTE);
      ev_ctrl_reg <= cot_ev_ctrl_t'(RESET_BYTE);
      int_en_reg  <= 1'b0;
    end else if (WR) begin
      if (ADDR == ADDR_CONTROL_A) begin
        ctrl_a_reg <= cot_ctrl_a_t'(WDATA & MASK_CONTROL_A);
      end
      if (ADDR == ADDR_CONTROL_B) begin
        ctrl_b_reg <= cot_ctrl_b_t'(WDATA & MASK_CONTROL_B);
      end
      if (ADDR == ADDR_EVENT_CTRL) begin
        ev_ctrl_reg <= cot_ev_ctrl_t'(WDATA & MASK_EVENT_CTRL);
      end
      if (ADDR == ADDR_INT_CTRL) begin
        int_en_reg <= WDATA[0];
      end
    end
  end

  // Byte pairing: low byte read latches high byte; low byte write parks data
  always_ff @(posedge CLK) begin
    if (RST) begin
      temp_reg <= RESET_BYTE;
    end else if (RD & (ADDR == ADDR_COUNT_LO)) begin
      temp_reg <= count_reg[15:8];
    end else if (RD & (ADDR == ADDR_CAPCMP_LO)) begin
      temp_reg <= cap_reg[15:8];
    end else if (WR & ((ADDR == ADDR_COUNT_LO) | (ADDR == ADDR_CAPCMP_LO)
                       | (ADDR == ADDR_TEMP))) begin
      temp_reg <= WDATA;
    end
  end

  always_comb begin
    rd_mux = RESET_BYTE;
    unique case (ADDR)
      ADDR_CONTROL_A:  rd_mux = ctrl_a_reg;
      ADDR_CONTROL_B:  rd_mux = ctrl_b_reg;
      ADDR_EVENT_CTRL: rd_mux = ev_ctrl_reg;
      ADDR_INT_CTRL:   rd_mux = {7'h00, int_en_reg};
      ADDR_INT_FLAGS:  rd_mux = {7'h00, flag_reg};
      ADDR_STATUS:     rd_mux = {7'h00, run_reg};
      ADDR_TEMP:       rd_mux = temp_reg;
      ADDR_COUNT_LO:   rd_mux = count_reg[7:0];
      ADDR_COUNT_HI:   rd_mux = temp_reg;
      ADDR_CAPCMP_LO:  rd_mux = cap_reg[7:0];
      ADDR_CAPCMP_HI:  rd_mux = temp_reg;
      default:         rd_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg <= RESET_BYTE;
    end else begin
      rdata_reg <= RD ? rd_mux : RESET_BYTE;
    end
  end

  assign RDATA = rdata_reg;

  // Counter: software write, companion restart, mode restart, count
  always_ff @(posedge CLK) begin
    if (RST) begin
      count_reg <= '0;
    end else if (WR & (ADDR == ADDR_COUNT_HI)) begin
      count_reg <= {WDATA, temp_reg};
    end else if (ctrl_a_reg.follow_partner_restart & PARTNER.restart) begin
      count_reg <= '0;
    end else if (do_restart) begin
      count_reg <= '0;
    end else if (count_run) begin
      if (mode == MODE_PWM) begin
        if (count_reg[7:0] >= cap_reg[7:0]) begin
          count_reg <= '0;
        end else begin
          count_reg <= {8'h00, count_reg[7:0] + 8'h01};
        end
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // Capture/compare value
  always_ff @(posedge CLK) begin
    if (RST) begin
      cap_reg <= '0;
    end else if (WR & (ADDR == ADDR_CAPCMP_HI)) begin
      cap_reg <= {WDATA, temp_reg};
    end else if (do_capture) begin
      cap_reg <= count_reg;
    end
  end

  // Capture flag: a set in the clearing cycle wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= set_flag | (flag_reg & ~flag_clr);
    end
  end

  assign CAPTURE_IRQ = flag_reg & int_en_reg;

  // Combined mode sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      cm_state_reg <= CM_IDLE;
    end else if (mode != MODE_FREQ_PULSE) begin
      cm_state_reg <= CM_IDLE;
    end else begin
      unique case (cm_state_reg)
        CM_IDLE:     if (lead_edge) cm_state_reg <= CM_COUNT;
        CM_COUNT:    if (trail_edge) cm_state_reg <= CM_MEASURED;
        CM_MEASURED: if (lead_edge) cm_state_reg <= CM_DONE;
        CM_DONE:     if (~flag_reg | flag_clr) cm_state_reg <= CM_IDLE;
      endcase
    end
  end

  // Single shot run and post-stop hold
  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_d_reg <= 1'b0;
      run_reg      <= 1'b0;
      hold_reg     <= 1'b0;
    end else begin
      enable_d_reg <= active;
      if (mode != MODE_SINGLE) begin
        run_reg  <= (mode == MODE_FREQ_PULSE) ? count_run : active;
        hold_reg <= 1'b0;
      end else if (ss_stop) begin
        run_reg  <= 1'b0;
        hold_reg <= 1'b1;
      end else if (ss_start) begin
        run_reg  <= 1'b1;
      end else if (hold_reg & tick) begin
        hold_reg <= 1'b0;
      end
    end
  end

  // Waveform output
  assign pwm_level = (cap_reg[7:0] != PWM_ZERO)
                     & (count_reg[7:0] < cap_reg[15:8]);

  always_comb begin
    wave_next = 1'b0;
    if (!ctrl_b_reg.output_drive_enable) begin
      wave_next = 1'b0;
    end else if (mode == MODE_SINGLE) begin
      wave_next = (run_reg & ~ss_stop)
                | (ctrl_b_reg.output_select_a & ss_start);
    end else if (mode == MODE_PWM) begin
      wave_next = pwm_level;
    end else begin
      wave_next = ctrl_b_reg.output_initial_level;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wave_reg  <= 1'b0;
      evout_reg <= 1'b0;
    end else begin
      wave_reg  <= wave_next;
      evout_reg <= set_flag | ss_stop;
    end
  end

  assign WAVE_OUT  = wave_reg;
  assign EVENT_OUT = evout_reg;

  // Checks
  freq_capture_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_FREQ) && lead_edge && !WR |=> flag_reg && (cap_reg == $past(count_reg)))
    else $error("frequency capture missed");

  pulse_restart_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_PULSE) && lead_edge && !WR |=> (count_reg == '0))
    else $error("pulse width restart missed");

  combo_stop_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_FREQ_PULSE) && (cm_state_reg == CM_MEASURED) && lead_edge && !WR
    |=> flag_reg && (cm_state_reg == CM_DONE) ##1 $stable(count_reg) || $past(WR))
    else $error("combined mode did not stop");

  shot_sync_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_SINGLE) && !ctrl_b_reg.output_select_a && ctrl_b_reg.output_drive_enable
    && ss_start && (cap_reg > 16'h0002) && !WR ##1 !WR |=> WAVE_OUT)
    else $error("single shot output late");

  shot_output_select_a_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_SINGLE) && ctrl_b_reg.output_select_a && ctrl_b_reg.output_drive_enable
    && ss_start && !WR |=> WAVE_OUT)
    else $error("asynchronous output late");

  shot_ignore_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_SINGLE) && hold_reg && ss_trig && !tick |=> !run_reg)
    else $error("event accepted during hold");

  pwm_low_a: assert property (@(posedge CLK) disable iff (RST)
    (mode == MODE_PWM) && (cap_reg[15:8] == PWM_ZERO) |=> !WAVE_OUT)
    else $error("pwm output high with zero duty");

  drive_off_a: assert property (@(posedge CLK) disable iff (RST)
    !ctrl_b_reg.output_drive_enable [*2] |-> !WAVE_OUT)
    else $error("output driven while disabled");

  irq_level_a: assert property (@(posedge CLK) disable iff (RST)
    set_flag && int_en_reg && !WR |=> CAPTURE_IRQ)
    else $error("interrupt not raised");

  filter_hold_a: assert property (@(posedge CLK) disable iff (RST)
    ev_ctrl_reg.filter_enable && !(&hist_reg) && (|hist_reg) |=> $stable(filt_reg))
    else $error("filter passed unstable level");

  cover_freq_c:  cover property (@(posedge CLK) disable iff (RST)
    (mode == MODE_FREQ) && set_flag);
  cover_combo_c: cover property (@(posedge CLK) disable iff (RST)
    (cm_state_reg == CM_DONE) && flag_clr);
  cover_shot_c:  cover property (@(posedge CLK) disable iff (RST) ss_start ##[1:300] ss_stop);
  cover_pwm_c:   cover property (@(posedge CLK) disable iff (RST)
    (mode == MODE_PWM) && WAVE_OUT ##1 !WAVE_OUT);

endmodule

// ---- bench/cot_partner_model.sv ----
`timescale 1ns/1ps
// Companion timer: tick every div cycles, event ticks when asked, restart on request
module cot_partner_model
  import cot_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control from the bench
  input  wire logic [3:0]   div,
  input  wire logic         restart_req,
  input  wire logic         ev_count,
  // Signals to the timer
  output cot_partner_t      partner
);
  logic [3:0] tick_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || restart_req || tick_cnt_reg == div - 4'h1) begin
      tick_cnt_reg <= 4'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  // Ticks are single-cycle pulses on the shared clock
  assign partner.clk_tick       = !rst && tick_cnt_reg == 4'h0;
  assign partner.event_tick     = !rst && ev_count && tick_cnt_reg[0];
  assign partner.count_on_event = ev_count;
  assign partner.restart        = restart_req;
endmodule

// ---- bench/capture_oneshot_pwm_timer_tb.sv ----
`timescale 1ns/1ps
module capture_oneshot_pwm_timer_tb
  import cot_pkg::*;
;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, EVENT_IN = 0, SLEEP_STANDBY = 0, SLEEP_POWERDOWN = 0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic WAVE_OUT, EVENT_OUT, CAPTURE_IRQ, rs_req = 0, cnt_ev = 0;
  cot_partner_t PARTNER;
  int errors = 0, num_checks = 0;
  int ev_pulses = 0;

  always #12.5 CLK = ~CLK;
  cot_partner_model cot_partner_model_i (.clk(CLK), .rst(RST), .div(4'h4),
    .restart_req(rs_req), .ev_count(cnt_ev), .partner(PARTNER));
  cot_timer cot_timer_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EVENT_IN(EVENT_IN), .PARTNER(PARTNER), .SLEEP_STANDBY(SLEEP_STANDBY),
    .SLEEP_POWERDOWN(SLEEP_POWERDOWN), .WAVE_OUT(WAVE_OUT), .EVENT_OUT(EVENT_OUT),
    .CAPTURE_IRQ(CAPTURE_IRQ));

  // Counts one-cycle event strobes
  always @(posedge CLK) begin
    if (EVENT_OUT === 1'b1) ev_pulses <= ev_pulses + 1;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge CLK);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  task automatic setup(input logic [7:0] ca, cb, ev, input logic [15:0] cnt, cap);
    wr(ADDR_CONTROL_A, 8'h00);
    wr(ADDR_INT_FLAGS, 8'h01);
    wr(ADDR_CONTROL_B, cb);
    wr(ADDR_EVENT_CTRL, ev);
    wr16(ADDR_COUNT_LO, cnt);
    wr16(ADDR_CAPCMP_LO, cap);
    wr(ADDR_CONTROL_A, ca);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_CONTROL_A, d); chk("ctrl_a rst", d, RESET_BYTE);
    rd(ADDR_CONTROL_B, d); chk("ctrl_b rst", d, RESET_BYTE);
    rd(ADDR_EVENT_CTRL, d); chk("ev rst", d, RESET_BYTE);
    wr(ADDR_CONTROL_B, 8'hFF);
    rd(ADDR_CONTROL_B, d); chk("ctrl_b mask", d, MASK_CONTROL_B);
    wr(4'h2, 8'hFF);
    rd(4'h2, d); chk("unmapped", d, 8'h00);
    wr(ADDR_CONTROL_B, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_freq();
    logic [7:0] d;
    int p;
    logic [15:0] v;
    setup(8'h01, {5'h06, MODE_FREQ}, 8'h01, 16'h0, 16'h0);
    wr(ADDR_INT_CTRL, 8'h01);
    chk("init level", WAVE_OUT, 1'b1);
    p = ev_pulses;
    EVENT_IN <= 1'b1; cyc(10); EVENT_IN <= 1'b0; cyc(10); EVENT_IN <= 1'b1; cyc(8);
    chk("event strobes", 16'(ev_pulses - p), 16'h0002);
    chk("irq set", CAPTURE_IRQ, 1'b1);
    rd(ADDR_INT_FLAGS, d); chk("flag set", d, 8'h01);
    wr(ADDR_INT_CTRL, 8'h00);
    chk("irq masked", CAPTURE_IRQ, 1'b0);
    rd16(ADDR_CAPCMP_LO, v); chk("freq capture", v, 16'd19);
    rd(ADDR_INT_FLAGS, d); chk("flag cleared", d, 8'h00);
    EVENT_IN <= 1'b0;
    setup(8'h01, {5'h00, MODE_FREQ}, 8'h00, 16'h0, 16'h0);
    EVENT_IN <= 1'b1; cyc(8); EVENT_IN <= 1'b0; cyc(8);
    rd(ADDR_INT_FLAGS, d); chk("ev disabled", d, 8'h00);
    setup(8'h01, {5'h00, MODE_FREQ}, 8'h41, 16'h0, 16'h0);
    EVENT_IN <= 1'b1; cyc(2); EVENT_IN <= 1'b0; cyc(12);
    rd(ADDR_INT_FLAGS, d); chk("glitch filtered", d, 8'h00);
    EVENT_IN <= 1'b1; cyc(6);
    rd(ADDR_INT_FLAGS, d); chk("filter delay", d, 8'h00);
    cyc(4);
    rd(ADDR_INT_FLAGS, d); chk("filtered edge", d, 8'h01);
    EVENT_IN <= 1'b0;
    $display("test freq done");
  endtask

  task automatic t_pulse();
    logic [7:0] d;
    logic [15:0] v;
    setup(8'h01, {5'h00, MODE_PULSE}, 8'h01, 16'h0, 16'h0);
    EVENT_IN <= 1'b1; cyc(6);
    rd(ADDR_INT_FLAGS, d); chk("no flag on rise", d, 8'h00);
    cyc(4); EVENT_IN <= 1'b0; cyc(8);
    rd16(ADDR_CAPCMP_LO, v); chk("pulse capture", v, 16'd11);
    setup(8'h01, {5'h00, MODE_FREQ_PULSE}, 8'h01, 16'h0, 16'h0);
    EVENT_IN <= 1'b1; cyc(8); EVENT_IN <= 1'b0; cyc(4);
    rd(ADDR_INT_FLAGS, d); chk("no flag on fall", d, 8'h00);
    cyc(2); EVENT_IN <= 1'b1; cyc(8);
    rd(ADDR_INT_FLAGS, d); chk("flag second rise", d, 8'h01);
    rd16(ADDR_CAPCMP_LO, v); chk("combo capture", v, 16'd7);
    rd(ADDR_INT_FLAGS, d); chk("combo cleared", d, 8'h00);
    EVENT_IN <= 1'b0;
    $display("test pulse done");
  endtask

  task automatic shot(input logic as, ed, output int lat, hi, logic fell);
    setup(8'h01, {1'b0, as, 3'h2, MODE_SINGLE}, {3'h0, ed, 4'h1}, 16'h5, 16'h5);
    cyc(6);
    chk("shot idle", WAVE_OUT, 1'b0);
    EVENT_IN <= 1'b1;
    for (lat = 1; lat < 30; lat++) begin @(posedge CLK); #1 if (WAVE_OUT === 1'b1) break; end
    for (hi = 1; hi < 30; hi++) begin @(posedge CLK); #1 if (WAVE_OUT !== 1'b1) break; end
    @(posedge CLK); cyc(4);
    EVENT_IN <= 1'b0; fell = 0;
    repeat (12) begin @(posedge CLK); #1 fell |= WAVE_OUT; end
    @(posedge CLK);
  endtask
  task automatic t_shot();
    int ls, la, hs, ha;
    logic f0, f1;
    logic [7:0] d;
    shot(1'b0, 1'b0, ls, hs, f0);
    shot(1'b1, 1'b1, la, ha, f1);
    setup(8'h01, {5'h02, MODE_SINGLE}, 8'h00, 16'h0, 16'h5);
    cyc(2);
    chk("start on enable", WAVE_OUT, 1'b1);
    rd(ADDR_STATUS, d); chk("running", d, 8'h01);
    cyc(6);
    chk("sync latency", ls >= 4 && ls <= 8, 1'b1);
    chk("output_select_a earlier", la < ls, 1'b1);
    chk("shot width", hs >= 5 && hs <= 8, 1'b1);
    chk("rise only", f0, 1'b0);
    chk("any edge", f1, 1'b1);
    $display("test shot done");
  endtask

  task automatic t_pwm();
    logic [7:0] cb, du;
    int h, e;
    for (int k = 0; k < 5; k++) begin
      du = (k == 4) ? 8'h02 : 8'(k * 2);
      cb = (k == 4) ? {5'h00, MODE_PWM} : {5'h02, MODE_PWM};
      e = (k == 4) ? 0 : (k == 3) ? 16 : k * 8;
      setup(8'h00, cb, 8'h00, 16'h0, {du, 8'h03});
      wr(ADDR_CONTROL_A, 8'h01);
      cyc(8); h = 0;
      repeat (16) begin @(posedge CLK); #1 h += WAVE_OUT; end
      @(posedge CLK);
      chk("pwm high cycles", 16'(h), 16'(e));
    end
    $display("test pwm done");
  endtask

  task automatic t_clock();
    logic [15:0] v, w;
    int lo, hi;
    // Passes 0..3 walk the clock field; pass 4 counts on companion event ticks
    for (int s = 0; s < 5; s++) begin
      cnt_ev <= (s == 4);
      setup({5'h00, ((s == 4) ? CLKSRC_PARTNER : 2'(s)), 1'b1}, 8'h00, 8'h00, 16'h0, 16'h0);
      cyc(40); rd16(ADDR_COUNT_LO, v);
      lo = (s == 3) ? 0 : (s == 4) ? 19 : (42 >> s) - 2;
      hi = (s == 3) ? 0 : lo + 6;
      chk("count rate", v >= 16'(lo) && v <= 16'(hi), 1'b1);
    end
    setup(8'h11, 8'h00, 8'h00, 16'hFFF0, 16'h0);
    cyc(20); rs_req <= 1'b1; @(posedge CLK); rs_req <= 1'b0; cyc(1);
    rd16(ADDR_COUNT_LO, v); chk("follow restart", v < 16'd8, 1'b1);
    SLEEP_POWERDOWN <= 1'b1;
    rd16(ADDR_COUNT_LO, v); cyc(6); rd16(ADDR_COUNT_LO, w);
    chk("powerdown halt", w, v);
    SLEEP_POWERDOWN <= 1'b0; SLEEP_STANDBY <= 1'b1;
    rd16(ADDR_COUNT_LO, v); cyc(6); rd16(ADDR_COUNT_LO, w);
    chk("standby halt", w, v);
    wr(ADDR_CONTROL_A, 8'h41);
    rd16(ADDR_COUNT_LO, v); cyc(6); rd16(ADDR_COUNT_LO, w);
    chk("standby run", w != v, 1'b1);
    SLEEP_STANDBY <= 1'b0;
    $display("test clock done");
  endtask

  initial begin
    cyc(16);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_freq();
    t_pulse();
    t_shot();
    t_pwm();
    t_clock();
    end_sim();
  end

  // Whole run is about a thousand cycles
  initial begin
    #(25 * 20000);
    errors++;
    end_sim();
  end
endmodule
